// [core/bus_share_pkg.sv]
// Shared constants and carrier types for the memory bus share arbiter
package bus_share_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int TAP_CLEAR_NS = 0;
    localparam int TAP_CUTOFF_NS = 45;
    localparam int TAP_GRANT_NS = 105;
    localparam int TAP_RESET_PRIO_NS = 150;
    localparam int TAP_REARM_NS = 210;
    localparam int TAP_CLEAR_CYC = (TAP_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP_CUTOFF_CYC = (TAP_CUTOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP_GRANT_CYC = (TAP_GRANT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP_RESET_PRIO_CYC = (TAP_RESET_PRIO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP_REARM_CYC = (TAP_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP_COUNT_W = 8;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] HIGH_GRANTS_OFFSET = 12'h008;
    localparam logic [11:0] LOW_GRANTS_OFFSET = 12'h00C;
    localparam int CTRL_ARB_ENABLE_BIT = 0;
    localparam logic CTRL_ARB_ENABLE_RESET = 1'b1;
    localparam int STATUS_ROLE_HIGH_BIT = 0;
    localparam int STATUS_HIGH_PRIO_BIT = 1;
    localparam int STATUS_LOW_PRIO_BIT = 2;
    localparam int STATUS_SEQ_ENABLE_BIT = 3;
    localparam int STATUS_HIGH_CYCLE_BIT = 4;
    localparam int STATUS_HIGH_LOCKOUT_BIT = 5;
    localparam int STATUS_LOW_CYCLE_BIT = 6;
    localparam int STATUS_LOW_LOCKOUT_BIT = 7;
    localparam int STATUS_RUNNING_BIT = 8;
    localparam int STATUS_COUNT_LSB = 16;
    localparam int GRANT_COUNT_W = 16;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // Pins arriving from the partner unit
    typedef struct packed {
        logic busRequest;
        logic cycleDisableReturn;
        logic requestEnableReturn;
        logic cycleEnable;
        logic interfaceClearLine;
    } link_in_t;

    // Pins driven toward the partner unit
    typedef struct packed {
        logic busRequest;
        logic lowUnitCycleEnable;
        logic lowUnitRequestLockout;
        logic interfaceClearLine;
        logic cycleDisableReturn;
        logic requestEnableReturn;
    } link_out_t;

    // Processing phases in which a bus request may be raised
    typedef struct packed {
        logic secondSequencePhase;
        logic firstDataOutPhase;
        logic dataInMemoryPhase;
        logic firstChainingPhase;
    } phase_t;

    typedef enum logic {ROLE_LOW, ROLE_HIGH} role_t;

endpackage

// [core/sync_two_stage.sv]
// Two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module sync_two_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // First stage feeds the second stage only
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage1_ff[i] <= RESET_VALUE[i];
                    stage2_ff[i] <= RESET_VALUE[i];
                end else begin
                    stage1_ff[i] <= asyncIn[i];
                    stage2_ff[i] <= stage1_ff[i];
                end
            end
        end
    endgenerate

    assign syncOut = stage2_ff;

endmodule

// [core/tap_sequencer.sv]
// Synchronous counter that stands in for the arbitration delay line
`timescale 1ns/1ps
module tap_sequencer #(
    parameter int COUNT_W = 8,
    parameter int LAST_TAP = 53
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic startReq,
    output logic running,
    output logic [COUNT_W-1:0] count
);

    logic running_ff;
    logic [COUNT_W-1:0] count_ff;
    logic atLast;

    assign atLast = running_ff && (count_ff == COUNT_W'(LAST_TAP));

    // Count 0 is the first tap; the run ends after the last tap
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            running_ff <= 1'b0;
            count_ff <= '0;
        end else if (!running_ff) begin
            running_ff <= startReq;
            count_ff <= '0;
        end else begin
            running_ff <= !atLast;
            count_ff <= atLast ? '0 : count_ff + COUNT_W'(1);
        end
    end

    assign running = running_ff;
    assign count = count_ff;

endmodule

// [core/memory_bus_share_arbiter.sv]
// Memory bus share arbiter: priority latches, tap sequence, grants and APB registers
`timescale 1ns/1ps

module memory_bus_share_arbiter
    import bus_share_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire bus_share_pkg::apb_req_t apbReq,
    output bus_share_pkg::apb_rsp_t apbRsp,
    input wire logic highPrioritySelect,
    input wire bus_share_pkg::link_in_t linkIn,
    output bus_share_pkg::link_out_t linkOut,
    input wire logic localMemoryRequest,
    input wire bus_share_pkg::phase_t localPhase,
    input wire logic localCycleDisableReturn,
    input wire logic localRequestEnableReturn,
    output logic memoryChainStartEnable,
    output logic interfaceClear
);
    import bus_share_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [5:0] pinsSync;
    logic roleSelSync;
    link_in_t linkSync;

    // Returns idle high, so they reset high to avoid a false release
    sync_two_stage #(
        .WIDTH(6),
        .RESET_VALUE(6'h0C)
    ) u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .asyncIn({highPrioritySelect, linkIn}),
        .syncOut(pinsSync)
    );

    assign roleSelSync = pinsSync[5];
    assign linkSync = link_in_t'(pinsSync[4:0]);

    // ------------------------------------------------------------
    // Role strap, caught once after reset release
    // ------------------------------------------------------------
    role_t role_ff;
    logic roleCaught_ff;
    logic [1:0] roleWait_ff;
    logic roleHigh;

    // Wait until the synchroniser holds the strap, not its own reset value
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            role_ff <= ROLE_LOW;
            roleCaught_ff <= 1'b0;
            roleWait_ff <= 2'h0;
        end else if (!roleCaught_ff) begin
            roleWait_ff <= roleWait_ff + 2'h1;
            if (roleWait_ff == 2'h2) begin
                role_ff <= roleSelSync ? ROLE_HIGH : ROLE_LOW;
                roleCaught_ff <= 1'b1;
            end
        end
    end

    // Arbitration stays off until the role is known
    assign roleHigh = roleCaught_ff && (role_ff == ROLE_HIGH);

    // ------------------------------------------------------------
    // Registers controlled by software
    // ------------------------------------------------------------
    logic arbEnable_ff;
    logic [GRANT_COUNT_W-1:0] highGrants_ff;
    logic [GRANT_COUNT_W-1:0] lowGrants_ff;

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    logic phaseOk;
    logic localReq;
    logic remoteReq;

    assign phaseOk = |localPhase;
    assign localReq = localMemoryRequest && phaseOk;
    // Only the low unit's request arrives on the link
    assign remoteReq = linkSync.busRequest;

    // ------------------------------------------------------------
    // Arbitration state (high role)
    // ------------------------------------------------------------
    logic highPrio_ff;
    logic lowPrio_ff;
    logic seqEnable_ff;
    logic highCycle_ff;
    logic highLockout_ff;
    logic lowCycle_ff;
    logic lowLockout_ff;
    logic clearPulse_ff;

    logic tapRunning;
    logic [TAP_COUNT_W-1:0] tapCount;
    logic notFirstTap;
    logic tapFirst;
    logic tapCutoff;
    logic tapGrant;
    logic tapResetPrio;
    logic tapRearm;
    logic busNotInUse;
    logic setAllowed;
    logic nxt_highPrio;
    logic nxt_lowPrio;
    logic seqStart;

    tap_sequencer #(
        .COUNT_W(TAP_COUNT_W),
        .LAST_TAP(TAP_REARM_CYC)
    ) u_taps (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .startReq(seqStart),
        .running(tapRunning),
        .count(tapCount)
    );

    // Each tap is one counter state; rounding up keeps the order intact
    assign tapFirst = tapRunning && (tapCount == TAP_COUNT_W'(TAP_CLEAR_CYC));
    assign tapCutoff = tapRunning && (tapCount == TAP_COUNT_W'(TAP_CUTOFF_CYC));
    assign tapGrant = tapRunning && (tapCount == TAP_COUNT_W'(TAP_GRANT_CYC));
    assign tapResetPrio = tapRunning && (tapCount == TAP_COUNT_W'(TAP_RESET_PRIO_CYC));
    assign tapRearm = tapRunning && (tapCount == TAP_COUNT_W'(TAP_REARM_CYC));
    assign notFirstTap = !tapFirst;

    // Any held grant or lockout means the bus is busy
    assign busNotInUse = !(highCycle_ff || highLockout_ff || lowCycle_ff || lowLockout_ff);
    assign setAllowed = roleHigh && arbEnable_ff && busNotInUse && notFirstTap && seqEnable_ff;

    // The high latch is tested first so the low latch can never win a tie
    assign nxt_highPrio = highPrio_ff || (setAllowed && localReq);
    assign nxt_lowPrio = lowPrio_ff || (setAllowed && remoteReq && !nxt_highPrio);
    assign seqStart = (highPrio_ff || lowPrio_ff) && seqEnable_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            highPrio_ff <= 1'b0;
            lowPrio_ff <= 1'b0;
        end else if (tapResetPrio) begin
            highPrio_ff <= 1'b0;
            lowPrio_ff <= 1'b0;
        end else begin
            highPrio_ff <= nxt_highPrio;
            lowPrio_ff <= nxt_lowPrio;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seqEnable_ff <= 1'b1;
        end else if (tapCutoff) begin
            seqEnable_ff <= 1'b0;
        end else if (tapRearm) begin
            seqEnable_ff <= 1'b1;
        end
    end

    // One-cycle clear at the first tap, registered for a clean pin
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clearPulse_ff <= 1'b0;
        end else begin
            clearPulse_ff <= tapFirst;
        end
    end

    // ------------------------------------------------------------
    // Grant and lockout latches; the setting tap wins over a release
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            highCycle_ff <= 1'b0;
            highLockout_ff <= 1'b0;
        end else if (tapGrant && highPrio_ff) begin
            highCycle_ff <= 1'b1;
            highLockout_ff <= 1'b1;
        end else begin
            if (!localCycleDisableReturn) begin
                highCycle_ff <= 1'b0;
            end
            if (!localRequestEnableReturn) begin
                highLockout_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lowCycle_ff <= 1'b0;
            lowLockout_ff <= 1'b0;
        end else if (tapGrant && lowPrio_ff && !highPrio_ff) begin
            lowCycle_ff <= 1'b1;
            lowLockout_ff <= 1'b1;
        end else begin
            if (!linkSync.cycleDisableReturn) begin
                lowCycle_ff <= 1'b0;
            end
            if (!linkSync.requestEnableReturn) begin
                lowLockout_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Low role: request toward the partner
    // ------------------------------------------------------------
    logic lowReqOut_ff;
    logic lowMemoryStart;

    // Held until the grant is seen; re-raised only after the grant falls
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lowReqOut_ff <= 1'b0;
        end else if (roleHigh || !roleCaught_ff || linkSync.cycleEnable) begin
            lowReqOut_ff <= 1'b0;
        end else if (localReq) begin
            lowReqOut_ff <= 1'b1;
        end
    end

    // Memory requests in the low role depend on the partner's grant
    assign lowMemoryStart = !roleHigh && linkSync.cycleEnable;

    // ------------------------------------------------------------
    // Link and local outputs
    // ------------------------------------------------------------
    logic chainStart_ff;
    logic localClear_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chainStart_ff <= 1'b0;
            localClear_ff <= 1'b0;
        end else begin
            chainStart_ff <= roleHigh ? highCycle_ff : lowMemoryStart;
            localClear_ff <= roleHigh ? tapFirst : linkSync.interfaceClearLine;
        end
    end

    assign memoryChainStartEnable = chainStart_ff;
    assign interfaceClear = localClear_ff;

    // Release returns come from the local sequencer in the low role
    assign linkOut.busRequest = lowReqOut_ff;
    assign linkOut.lowUnitCycleEnable = lowCycle_ff;
    assign linkOut.lowUnitRequestLockout = lowLockout_ff;
    assign linkOut.interfaceClearLine = clearPulse_ff;
    assign linkOut.cycleDisableReturn = roleHigh ? 1'b1 : localCycleDisableReturn;
    assign linkOut.requestEnableReturn = roleHigh ? 1'b1 : localRequestEnableReturn;

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    logic apbWrite;
    logic selCtrl;
    logic selStatus;
    logic selHighGrants;
    logic selLowGrants;
    logic mapped;
    logic [31:0] statusWord;
    logic [31:0] readData;
    logic highGrantEvent;
    logic lowGrantEvent;

    assign selCtrl = (apbReq.paddr == CTRL_OFFSET);
    assign selStatus = (apbReq.paddr == STATUS_OFFSET);
    assign selHighGrants = (apbReq.paddr == HIGH_GRANTS_OFFSET);
    assign selLowGrants = (apbReq.paddr == LOW_GRANTS_OFFSET);
    assign mapped = selCtrl || selStatus || selHighGrants || selLowGrants;
    assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite && mapped;

    assign highGrantEvent = tapGrant && highPrio_ff;
    assign lowGrantEvent = tapGrant && lowPrio_ff && !highPrio_ff;

    assign statusWord = {
        8'h00,
        tapCount,
        7'h00,
        tapRunning,
        lowLockout_ff,
        lowCycle_ff,
        highLockout_ff,
        highCycle_ff,
        seqEnable_ff,
        lowPrio_ff,
        highPrio_ff,
        roleHigh
    };

    assign readData = selCtrl ? {31'h00000000, arbEnable_ff}
        : selStatus ? statusWord
        : selHighGrants ? {16'h0000, highGrants_ff}
        : selLowGrants ? {16'h0000, lowGrants_ff}
        : 32'h00000000;

    assign apbRsp.prdata = readData;
    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            arbEnable_ff <= CTRL_ARB_ENABLE_RESET;
        end else if (apbWrite && selCtrl) begin
            arbEnable_ff <= apbReq.pwdata[CTRL_ARB_ENABLE_BIT];
        end
    end

    // A grant landing on the clearing write still counts
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            highGrants_ff <= '0;
            lowGrants_ff <= '0;
        end else begin
            if (apbWrite && selHighGrants) begin
                highGrants_ff <= GRANT_COUNT_W'(highGrantEvent);
            end else if (highGrantEvent) begin
                highGrants_ff <= highGrants_ff + GRANT_COUNT_W'(1);
            end
            if (apbWrite && selLowGrants) begin
                lowGrants_ff <= GRANT_COUNT_W'(lowGrantEvent);
            end else if (lowGrantEvent) begin
                lowGrants_ff <= lowGrants_ff + GRANT_COUNT_W'(1);
            end
        end
    end

endmodule

// [test/bus_arbiter_monitor.sv]
// Concurrent checks on the arbiter link pins
`timescale 1ns/1ps
module bus_arbiter_monitor
    import bus_share_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire bus_share_pkg::link_in_t linkIn,
    input wire bus_share_pkg::link_out_t linkOut,
    input wire logic memoryChainStartEnable,
    input wire logic interfaceClear
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ----
    // Arbitration steps
    // ----
    sequence s_clearPulse;
        $rose(linkOut.interfaceClearLine) ##1 !linkOut.interfaceClearLine;
    endsequence
    sequence s_anyGrant;
        $rose(linkOut.lowUnitCycleEnable) || $rose(memoryChainStartEnable);
    endsequence
    a_clear_one_cycle: assert property (s_clearPulse or !$rose(linkOut.interfaceClearLine))
        else $error("clear pulse too long");
    a_clear_spacing: assert property ($rose(linkOut.interfaceClearLine) |=> (!linkOut.interfaceClearLine)[*8])
        else $error("clear pulses too close");
    a_grant_follows_clear: assert property (s_clearPulse |-> ##[22:30] s_anyGrant)
        else $error("no grant after clear");
    a_local_clear: assert property ($rose(linkOut.interfaceClearLine) |-> ##[0:2] interfaceClear)
        else $error("local clear missing");
    a_lockout_with_grant: assert property ($rose(linkOut.lowUnitCycleEnable) |-> $rose(linkOut.lowUnitRequestLockout))
        else $error("lockout not raised with grant");
    a_grant_release: assert property ($fell(linkIn.cycleDisableReturn) && linkOut.lowUnitCycleEnable
        |-> ##[1:5] !linkOut.lowUnitCycleEnable)
        else $error("grant not dropped");
    a_lock_release: assert property ($fell(linkIn.requestEnableReturn) && linkOut.lowUnitRequestLockout
        |-> ##[1:5] !linkOut.lowUnitRequestLockout)
        else $error("lockout not dropped");
    a_lock_blocks: assert property (linkOut.lowUnitRequestLockout |-> !$rose(linkOut.interfaceClearLine))
        else $error("arbitration under lockout");
    a_high_wins: assert property (memoryChainStartEnable |-> !linkOut.lowUnitCycleEnable)
        else $error("both units granted");
endmodule
bind memory_bus_share_arbiter bus_arbiter_monitor u_mon (.core_clk(core_clk), .arst_n(arst_n), .linkIn(linkIn),
    .linkOut(linkOut), .memoryChainStartEnable(memoryChainStartEnable), .interfaceClear(interfaceClear));

// [test/low_unit_model.sv]
// Behavioural low-priority peer unit on the far side of the link
`timescale 1ns/1ps
module low_unit_model
    import bus_share_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wantBus,
    input wire logic [7:0] holdCyc,
    input wire bus_share_pkg::link_out_t linkOut,
    output bus_share_pkg::link_in_t linkIn
);
    logic busReq_ff, disableRet_ff, enableRet_ff, busy_ff;
    logic [7:0] access_ff;
    // Grant and clear lines belong to the high unit, so the peer leaves them low
    assign linkIn = '{busRequest: busReq_ff, cycleDisableReturn: disableRet_ff,
        requestEnableReturn: enableRet_ff, cycleEnable: 1'b0, interfaceClearLine: 1'b0};
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busReq_ff <= 1'b0;
            disableRet_ff <= 1'b1;
            enableRet_ff <= 1'b1;
            busy_ff <= 1'b0;
            access_ff <= 8'h00;
        end else begin
            if (wantBus && !busy_ff) begin
                busReq_ff <= 1'b1;
                busy_ff <= 1'b1;
            end else if (busReq_ff && linkOut.lowUnitCycleEnable) begin
                busReq_ff <= 1'b0;
            end
            // Memory accesses counted only under the grant
            if (linkOut.lowUnitCycleEnable && disableRet_ff) begin
                access_ff <= access_ff + 8'h01;
            end
            if (access_ff == holdCyc) begin
                disableRet_ff <= 1'b0;
            end
            if (!disableRet_ff && !linkOut.lowUnitCycleEnable) begin
                enableRet_ff <= 1'b0;
            end
            // Restore last so it beats the release terms above
            if (!enableRet_ff && !linkOut.lowUnitRequestLockout) begin
                disableRet_ff <= 1'b1;
                enableRet_ff <= 1'b1;
                busy_ff <= 1'b0;
                access_ff <= 8'h00;
            end
        end
    end
endmodule

// [test/tb_memory_bus_share_arbiter.sv]
// Self-checking bench for the memory bus share arbiter
`timescale 1ns/1ps
module tb_memory_bus_share_arbiter;
    import bus_share_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic roleSel = 1'b1;
    apb_req_t apbReq = '0;
    apb_rsp_t apbRsp;
    link_in_t linkIn;
    link_out_t linkOut;
    logic localMemoryRequest = 1'b0;
    phase_t localPhase = '0;
    logic localCycleDisableReturn = 1'b1;
    logic localRequestEnableReturn = 1'b1;
    logic memoryChainStartEnable, interfaceClear;
    logic wantBus = 1'b0;
    logic [7:0] holdCyc = 8'h02;
    int miscompares = 0;
    int cmp_count = 0;
    int clrCnt = 0;
    int i;
    logic [31:0] rd;
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (linkOut.interfaceClearLine === 1'b1) clrCnt++;
    memory_bus_share_arbiter u_dut (.core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
        .highPrioritySelect(roleSel), .linkIn(linkIn), .linkOut(linkOut), .localMemoryRequest(localMemoryRequest),
        .localPhase(localPhase), .localCycleDisableReturn(localCycleDisableReturn),
        .localRequestEnableReturn(localRequestEnableReturn), .memoryChainStartEnable(memoryChainStartEnable),
        .interfaceClear(interfaceClear));
    low_unit_model u_peer (.core_clk(core_clk), .arst_n(arst_n), .wantBus(wantBus), .holdCyc(holdCyc),
        .linkOut(linkOut), .linkIn(linkIn));
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // The answer is taken at the rising edge that sees pready, before that edge's updates land
    task apb(input logic [11:0] a, input logic wr, input logic [31:0] wd, input logic [31:0] m,
        input logic [31:0] exp, input logic expErr);
        int n;
        logic rdy, err;
        n = 0;
        rdy = 1'b0;
        err = 1'b0;
        @(posedge core_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        while (rdy !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            rdy = apbRsp.pready;
            rd = apbRsp.prdata;
            err = apbRsp.pslverr;
            n++;
        end
        if (rdy !== 1'b1) miscompares++;
        apbReq <= '0;
        if (!wr) check(rd & m, exp, "read data");
        check({31'h0, err}, {31'h0, expErr}, "slave error");
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        apb(CTRL_OFFSET, 1'b0, '0, 32'hFFFFFFFF, 32'h1, 1'b0);
        apb(STATUS_OFFSET, 1'b0, '0, 32'h1FF, 32'h9, 1'b0);
        apb(STATUS_OFFSET, 1'b1, 32'hFFFFFFFF, '0, '0, 1'b0);
        apb(STATUS_OFFSET, 1'b0, '0, 32'h1FF, 32'h9, 1'b0);
        apb(12'h010, 1'b0, '0, 32'hFFFFFFFF, 32'h0, 1'b1);
        $display("test registers done");
        localMemoryRequest <= 1'b1;
        repeat (40) @(posedge core_clk);
        check(clrCnt, 0, "arbitration outside the phases");
        apb(CTRL_OFFSET, 1'b1, 32'h0, '0, '0, 1'b0);
        localPhase <= 4'b0100;
        repeat (40) @(posedge core_clk);
        check(clrCnt, 0, "arbitration while disabled");
        localMemoryRequest <= 1'b0;
        apb(CTRL_OFFSET, 1'b1, 32'h1, '0, '0, 1'b0);
        $display("test gating done");
        wantBus <= 1'b1;
        for (i = 0; i < 300 && linkOut.lowUnitCycleEnable !== 1'b1; i++) @(negedge core_clk);
        check(clrCnt, 1, "one clear per arbitration");
        check(linkOut.lowUnitRequestLockout, 1'b1, "lockout with grant");
        @(posedge core_clk);
        wantBus <= 1'b0;
        localMemoryRequest <= 1'b1;
        localPhase <= 4'b1000;
        for (i = 0; i < 100 && linkOut.lowUnitCycleEnable !== 1'b0; i++) @(negedge core_clk);
        check(linkOut.lowUnitRequestLockout, 1'b1, "lockout held past grant");
        for (i = 0; i < 100 && linkOut.lowUnitRequestLockout !== 1'b0; i++) @(negedge core_clk);
        check(memoryChainStartEnable, 1'b0, "request served under lockout");
        apb(LOW_GRANTS_OFFSET, 1'b0, '0, 32'hFFFF, 32'h1, 1'b0);
        apb(HIGH_GRANTS_OFFSET, 1'b1, 32'h0, '0, '0, 1'b0);
        $display("test peer grant done");
        holdCyc <= 8'h0C;
        wantBus <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            localPhase <= 4'b1000 >> p;
            localMemoryRequest <= 1'b1;
            for (i = 0; i < 600 && memoryChainStartEnable !== 1'b1; i++) @(negedge core_clk);
            check(linkOut.lowUnitCycleEnable, 1'b0, "own grant alone");
            @(posedge core_clk);
            localCycleDisableReturn <= 1'b0;
            for (i = 0; i < 10 && memoryChainStartEnable !== 1'b0; i++) @(negedge core_clk);
            check(memoryChainStartEnable, 1'b0, "own grant release");
            @(posedge core_clk);
            localRequestEnableReturn <= 1'b0;
            localMemoryRequest <= 1'b0;
            repeat (6) @(posedge core_clk);
            localCycleDisableReturn <= 1'b1;
            localRequestEnableReturn <= 1'b1;
        end
        wantBus <= 1'b0;
        apb(HIGH_GRANTS_OFFSET, 1'b0, '0, 32'hFFFF, 32'h4, 1'b0);
        $display("test phases done");
        roleSel <= 1'b0;
        arst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        apb(STATUS_OFFSET, 1'b0, '0, 32'h1FF, 32'h8, 1'b0);
        localPhase <= 4'b0010;
        localMemoryRequest <= 1'b1;
        localCycleDisableReturn <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(linkOut.busRequest, 1'b1, "low role request");
        check(linkOut.cycleDisableReturn, 1'b0, "low role release");
        check(memoryChainStartEnable, 1'b0, "low role access without grant");
        $display("test low role done");
        summarize();
    end
endmodule
